// *** pci_cfg_pkg.sv ***
package pci_cfg_pkg;

   // Dword byte offsets of the configuration header
   localparam logic [7:0] OFF_IDENT = 8'h00;
   localparam logic [7:0] OFF_CMD_STATUS = 8'h04;
   localparam logic [7:0] OFF_CLASS_REV = 8'h08;
   localparam logic [7:0] OFF_MISC = 8'h0C;
   localparam logic [7:0] OFF_REG_MEM_BASE = 8'h10;
   localparam logic [7:0] OFF_REG_IO_BASE = 8'h14;
   localparam logic [7:0] OFF_LOC_MEM_BASE = 8'h18;
   localparam logic [7:0] OFF_CARD_INFO = 8'h28;
   localparam logic [7:0] OFF_SUBSYS = 8'h2C;
   localparam logic [7:0] OFF_ROM_BASE = 8'h30;
   localparam logic [7:0] OFF_CAP_PTR = 8'h34;
   localparam logic [7:0] OFF_INTR_TIMING = 8'h3C;
   localparam logic [7:0] OFF_PWR_CAP = 8'h70;
   localparam logic [7:0] OFF_PWR_CTRL = 8'h74;

   // Device identifier sits in the upper half of the dword at 00h
   localparam int DEVICE_IDENTIFIER_LSB = 16;

   // Local processor window
   localparam logic [31:0] LOCAL_BASE = 32'h4200_0000;
   localparam int LOCAL_WIN_BITS = 8;

   // Command bit positions
   localparam int CMD_IO = 0;
   localparam int CMD_MEM = 1;
   localparam int CMD_MASTER = 2;
   localparam int CMD_SPECIAL = 3;
   localparam int CMD_MWI = 4;
   localparam int CMD_VGA = 5;
   localparam int CMD_PERR = 6;
   localparam int CMD_SERR = 8;
   localparam int CMD_FB2B = 9;
   localparam logic [15:0] CMD_RESET = 16'h0000;
   localparam logic [31:0] CMD_RW_MASK = 32'h0000_0357;

   // Status parity-detected bit, write one to clear
   localparam int STAT_PARITY_BIT = 31;
   localparam logic [31:0] STAT_W1C_MASK = 32'h8000_0000;

   // Writable bits of the other read/write dwords
   localparam logic [31:0] MISC_RW_MASK = 32'h0000_FFFF;
   localparam logic [31:0] REG_MEM_RW_MASK = 32'hFFFF_F000;
   localparam logic [31:0] REG_IO_RW_MASK = 32'hFFFF_FF80;
   localparam logic [31:0] REG_IO_FIXED = 32'h0000_0001;
   localparam logic [31:0] LOC_MEM_RW_MASK = 32'hFFF0_0000;
   localparam logic [31:0] ROM_RW_MASK = 32'hFFFF_F801;
   localparam logic [31:0] INTR_RW_MASK = 32'h0000_00FF;
   localparam logic [31:0] ZERO_MASK = 32'h0000_0000;
   localparam logic [31:0] DWORD_RESET = 32'h0000_0000;

endpackage

// *** pci_config_header_command.sv ***
`timescale 1ns/100ps
`default_nettype none

module pci_config_header_command #(
   parameter logic [15:0] VENDOR_CODE = 16'hA5A5,   // Arbitrary value
   parameter logic [15:0] DEVICE_CODE = 16'h5A5A,   // Arbitrary value
   parameter logic [31:0] CLASS_REV = 32'h0B40_0000,
   parameter logic [31:0] SUBSYS_CODE = 32'h0000_0000,
   parameter logic [7:0] INTR_PIN = 8'h01
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic cfg_req,
   input wire logic cfg_write,
   input wire logic [5:0] cfg_index,
   input wire logic [3:0] cfg_byte_en,
   input wire logic [31:0] cfg_wdata,
   output logic cfg_ack,
   output logic [31:0] cfg_rdata,
   input wire logic lp_req,
   input wire logic lp_write,
   input wire logic [31:0] lp_addr,
   input wire logic [3:0] lp_byte_en,
   input wire logic [31:0] lp_wdata,
   output logic lp_ack,
   output logic [31:0] lp_rdata,
   input wire logic io_addr_hit,
   input wire logic mem_addr_hit,
   input wire logic special_cycle,
   output logic io_target_claim,
   output logic mem_target_claim,
   output logic special_cycle_claim,
   output logic palette_snoop,
   input wire logic master_want,
   input wire logic outbound_load,
   input wire logic outbound_not_empty,
   output logic outbound_accept,
   output logic outbound_drain,
   output logic pci_bus_req,
   input wire logic mwi_want,
   output logic mwi_issue,
   input wire logic fb2b_want,
   output logic fb2b_issue,
   input wire logic data_parity_err,
   input wire logic addr_parity_err,
   output logic perr_drive,
   output logic serr_drive,
   output logic [15:0] command_bits
);

   typedef struct packed {
      logic [15:0] cmd;
      logic parity_seen;
      logic [31:0] misc;
      logic [31:0] reg_mem_base;
      logic [31:0] reg_io_base;
      logic [31:0] loc_mem_base;
      logic [31:0] rom_base;
      logic [31:0] intr;
      logic cfg_ack;
      logic lp_ack;
      logic [31:0] rdata;
   } state_s;

   state_s state_reg;
   state_s state_next;

   logic lp_in_window;
   logic pci_go;
   logic lp_go;
   logic acc_write;
   logic [5:0] acc_index;
   logic [3:0] acc_be;
   logic [31:0] acc_wdata;
   logic [31:0] rd_word;
   logic [31:0] cs_word;

   // Byte-lane write with per-bit access kinds
   function automatic logic [31:0] apply_wr(input logic [31:0] old, input logic [31:0] wd,
         input logic [3:0] be, input logic [31:0] rw, input logic [31:0] w1c,
         input logic [31:0] w0c, input logic [31:0] w1s);
      logic [31:0] lane;
      logic [31:0] nv;
      lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      nv = (old & ~(lane & rw)) | (wd & lane & rw);
      nv = nv & ~(wd & lane & w1c);
      nv = nv & ~(~wd & lane & w0c);
      nv = nv | (wd & lane & w1s);
      return nv;
   endfunction

   // Full dword seen at a header index
   function automatic logic [31:0] read_word(input logic [5:0] idx, input state_s s);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case ({idx, 2'b00})
         pci_cfg_pkg::OFF_IDENT: r = {DEVICE_CODE, VENDOR_CODE};
         pci_cfg_pkg::OFF_CMD_STATUS: begin
            r = {16'h0000, s.cmd};
            r[pci_cfg_pkg::STAT_PARITY_BIT] = s.parity_seen;
         end
         pci_cfg_pkg::OFF_CLASS_REV: r = CLASS_REV;
         pci_cfg_pkg::OFF_MISC: r = s.misc;
         pci_cfg_pkg::OFF_REG_MEM_BASE: r = s.reg_mem_base;
         pci_cfg_pkg::OFF_REG_IO_BASE: r = s.reg_io_base | pci_cfg_pkg::REG_IO_FIXED;
         pci_cfg_pkg::OFF_LOC_MEM_BASE: r = s.loc_mem_base;
         pci_cfg_pkg::OFF_SUBSYS: r = SUBSYS_CODE;
         pci_cfg_pkg::OFF_ROM_BASE: r = s.rom_base;
         pci_cfg_pkg::OFF_INTR_TIMING: r = {16'h0000, INTR_PIN, s.intr[7:0]};
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   // Arbitration: configuration transactions before local processor
   always_comb begin
      lp_in_window = lp_req && (lp_addr[31:pci_cfg_pkg::LOCAL_WIN_BITS] ==
            pci_cfg_pkg::LOCAL_BASE[31:pci_cfg_pkg::LOCAL_WIN_BITS]);
      pci_go = cfg_req && !state_reg.cfg_ack;
      lp_go = lp_in_window && !pci_go && !state_reg.lp_ack;
      acc_write = pci_go ? cfg_write : lp_write;
      acc_index = pci_go ? cfg_index : lp_addr[7:2];
      acc_be = pci_go ? cfg_byte_en : lp_byte_en;
      acc_wdata = pci_go ? cfg_wdata : lp_wdata;
      rd_word = read_word(acc_index, state_reg);
      cs_word = apply_wr({16'h0000, state_reg.cmd} |
            {state_reg.parity_seen, 31'h0000_0000}, acc_wdata, acc_be,
            pci_cfg_pkg::CMD_RW_MASK, pci_cfg_pkg::STAT_W1C_MASK,
            pci_cfg_pkg::ZERO_MASK, pci_cfg_pkg::ZERO_MASK);
   end

   always_comb begin
      state_next = state_reg;
      state_next.cfg_ack = pci_go;
      state_next.lp_ack = lp_go;
      if (pci_go || lp_go) begin
         state_next.rdata = acc_write ? state_reg.rdata : rd_word;
      end
      if ((pci_go || lp_go) && acc_write) begin
         unique case ({acc_index, 2'b00})
            pci_cfg_pkg::OFF_CMD_STATUS: begin
               state_next.cmd = cs_word[15:0];
               state_next.parity_seen = cs_word[pci_cfg_pkg::STAT_PARITY_BIT];
            end
            pci_cfg_pkg::OFF_MISC: state_next.misc = apply_wr(state_reg.misc, acc_wdata,
                  acc_be, pci_cfg_pkg::MISC_RW_MASK, pci_cfg_pkg::ZERO_MASK,
                  pci_cfg_pkg::ZERO_MASK, pci_cfg_pkg::ZERO_MASK);
            pci_cfg_pkg::OFF_REG_MEM_BASE: state_next.reg_mem_base = apply_wr(
                  state_reg.reg_mem_base, acc_wdata, acc_be, pci_cfg_pkg::REG_MEM_RW_MASK,
                  pci_cfg_pkg::ZERO_MASK, pci_cfg_pkg::ZERO_MASK, pci_cfg_pkg::ZERO_MASK);
            pci_cfg_pkg::OFF_REG_IO_BASE: state_next.reg_io_base = apply_wr(
                  state_reg.reg_io_base, acc_wdata, acc_be, pci_cfg_pkg::REG_IO_RW_MASK,
                  pci_cfg_pkg::ZERO_MASK, pci_cfg_pkg::ZERO_MASK, pci_cfg_pkg::ZERO_MASK);
            pci_cfg_pkg::OFF_LOC_MEM_BASE: state_next.loc_mem_base = apply_wr(
                  state_reg.loc_mem_base, acc_wdata, acc_be, pci_cfg_pkg::LOC_MEM_RW_MASK,
                  pci_cfg_pkg::ZERO_MASK, pci_cfg_pkg::ZERO_MASK, pci_cfg_pkg::ZERO_MASK);
            pci_cfg_pkg::OFF_ROM_BASE: state_next.rom_base = apply_wr(state_reg.rom_base,
                  acc_wdata, acc_be, pci_cfg_pkg::ROM_RW_MASK, pci_cfg_pkg::ZERO_MASK,
                  pci_cfg_pkg::ZERO_MASK, pci_cfg_pkg::ZERO_MASK);
            pci_cfg_pkg::OFF_INTR_TIMING: state_next.intr = apply_wr(state_reg.intr,
                  acc_wdata, acc_be, pci_cfg_pkg::INTR_RW_MASK, pci_cfg_pkg::ZERO_MASK,
                  pci_cfg_pkg::ZERO_MASK, pci_cfg_pkg::ZERO_MASK);
            default: state_next.rdata = state_reg.rdata;
         endcase
      end
      // Detection wins over a same-cycle clear
      if (data_parity_err || addr_parity_err) begin
         state_next.parity_seen = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg.cmd <= pci_cfg_pkg::CMD_RESET;
         state_reg.parity_seen <= 1'b0;
         state_reg.misc <= pci_cfg_pkg::DWORD_RESET;
         state_reg.reg_mem_base <= pci_cfg_pkg::DWORD_RESET;
         state_reg.reg_io_base <= pci_cfg_pkg::DWORD_RESET;
         state_reg.loc_mem_base <= pci_cfg_pkg::DWORD_RESET;
         state_reg.rom_base <= pci_cfg_pkg::DWORD_RESET;
         state_reg.intr <= pci_cfg_pkg::DWORD_RESET;
         state_reg.cfg_ack <= 1'b0;
         state_reg.lp_ack <= 1'b0;
         state_reg.rdata <= pci_cfg_pkg::DWORD_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // Command bits steering the rest of the device
   always_comb begin
      cfg_ack = state_reg.cfg_ack;
      lp_ack = state_reg.lp_ack;
      cfg_rdata = state_reg.rdata;
      lp_rdata = state_reg.rdata;
      command_bits = state_reg.cmd;
      io_target_claim = state_reg.cmd[pci_cfg_pkg::CMD_IO] && io_addr_hit;
      mem_target_claim = state_reg.cmd[pci_cfg_pkg::CMD_MEM] && mem_addr_hit;
      special_cycle_claim = state_reg.cmd[pci_cfg_pkg::CMD_SPECIAL] && special_cycle;
      palette_snoop = state_reg.cmd[pci_cfg_pkg::CMD_VGA];
      outbound_accept = outbound_load;
      outbound_drain = state_reg.cmd[pci_cfg_pkg::CMD_MASTER] && outbound_not_empty;
      pci_bus_req = state_reg.cmd[pci_cfg_pkg::CMD_MASTER] &&
            (master_want || outbound_not_empty);
      mwi_issue = state_reg.cmd[pci_cfg_pkg::CMD_MASTER] &&
            state_reg.cmd[pci_cfg_pkg::CMD_MWI] && mwi_want;
      fb2b_issue = state_reg.cmd[pci_cfg_pkg::CMD_FB2B] && fb2b_want;
      perr_drive = state_reg.cmd[pci_cfg_pkg::CMD_PERR] && data_parity_err;
      serr_drive = state_reg.cmd[pci_cfg_pkg::CMD_PERR] &&
            state_reg.cmd[pci_cfg_pkg::CMD_SERR] && addr_parity_err;
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   AST_CFG_WRITE_LANE: assert property (
      (pci_go && cfg_write && cfg_index == 6'h01 && cfg_byte_en[0])
      |=> io_target_claim == ($past(cfg_wdata[0]) && io_addr_hit)
   ) else $error("command byte write not taken");

   AST_CFG_LANE_MASK: assert property (
      (pci_go && cfg_write && cfg_index == 6'h01 && !cfg_byte_en[1])
      |=> $stable(command_bits[9:8])
   ) else $error("disabled byte lane changed command");

   AST_LOCAL_WINDOW: assert property (
      (lp_req && lp_addr[31:8] != 24'h42_0000 && !state_reg.lp_ack) |=> !lp_ack
   ) else $error("local access outside window answered");

   AST_LOCAL_READ: assert property (
      (lp_go && !lp_write && lp_addr[7:0] == 8'h00) ##1 lp_ack
      |-> lp_rdata == {DEVICE_CODE, VENDOR_CODE}
   ) else $error("local read of identifiers wrong");

   AST_STATUS_W1C: assert property (
      (pci_go && cfg_write && cfg_index == 6'h01 && cfg_byte_en[3] && cfg_wdata[31] &&
       !data_parity_err && !addr_parity_err)
      ##1 (lp_go && !lp_write && lp_addr[7:0] == 8'h04) |=> !lp_rdata[31]
   ) else $error("status write one did not clear");

   AST_IDENT_READ: assert property (
      (pci_go && !cfg_write && cfg_index == 6'h00) |=> cfg_ack && cfg_rdata[15:0] ==
            VENDOR_CODE && cfg_rdata[31:16] == DEVICE_CODE
   ) else $error("identifier read wrong");

   AST_IO_GATE: assert property (
      (io_addr_hit && !command_bits[0]) |-> !io_target_claim
   ) else $error("I/O claimed while disabled");

   AST_MEM_GATE: assert property (
      mem_target_claim |-> command_bits[1] && mem_addr_hit
   ) else $error("memory claimed while disabled");

   AST_MASTER_GATE: assert property (
      !command_bits[2] |-> !pci_bus_req && !outbound_drain && !mwi_issue
   ) else $error("bus requested while master disabled");

   AST_FIFO_HOLD: assert property (
      (outbound_load && !command_bits[2]) |-> outbound_accept && !outbound_drain
   ) else $error("outbound loading blocked or drained");

   AST_FIXED_ZERO: assert property (
      cfg_ack |-> !special_cycle_claim && !palette_snoop && command_bits[5:3] ==? 3'b0?0
   ) else $error("fixed command bits not zero");

   AST_MWI_GATE: assert property (
      (mwi_want && command_bits[2] && !command_bits[4]) |-> !mwi_issue
   ) else $error("invalidate issued while disabled");

   AST_PERR_GATE: assert property (
      data_parity_err |-> perr_drive == command_bits[6]
   ) else $error("parity drive wrong");

   AST_STATUS_SET: assert property (
      (data_parity_err || addr_parity_err) |=> state_reg.parity_seen [*1]
   ) else $error("parity detection not recorded");

   AST_SERR_GATE: assert property (
      serr_drive |-> command_bits[8] && command_bits[6] && addr_parity_err
   ) else $error("system error driven while disabled");

   AST_FB2B_GATE: assert property (
      fb2b_issue |-> command_bits[9]
   ) else $error("fast back-to-back without enable");

   AST_RESERVED_ZERO: assert property (
      (pci_go && !cfg_write && (cfg_index == 6'h07 || cfg_index == 6'h0E)) |=>
            cfg_rdata == 32'h0000_0000
   ) else $error("reserved offset read nonzero");

   AST_ACK_PULSE: assert property (
      cfg_ack |=> !cfg_ack
   ) else $error("configuration answer longer than one cycle");

   AST_CFG_ANSWER: assert property (
      (cfg_req && !cfg_ack) |=> cfg_ack
   ) else $error("configuration request not answered");

   AST_LOCAL_DEFER: assert property (
      (pci_go && lp_in_window) |=> !lp_ack
   ) else $error("local access answered during configuration access");

   AST_CLASS_READ: assert property (
      (pci_go && !cfg_write && cfg_index == 6'h02) |=> cfg_rdata == CLASS_REV
   ) else $error("class dword read wrong");

   AST_PARITY_WINS: assert property (
      (pci_go && cfg_write && cfg_index == 6'h01 && cfg_byte_en[3] && cfg_wdata[31] &&
       data_parity_err) |=> state_reg.parity_seen
   ) else $error("parity detection lost to same-cycle clear");

   AST_RESERVED_WRITE: assert property (
      (pci_go && cfg_write && (cfg_index == 6'h07 || cfg_index == 6'h0E)) |=>
            $stable({state_reg.cmd, state_reg.misc, state_reg.reg_mem_base,
            state_reg.reg_io_base, state_reg.loc_mem_base, state_reg.rom_base, state_reg.intr})
   ) else $error("reserved offset write changed a register");

   AST_SERR_ENABLE: assert property (
      (addr_parity_err && command_bits[6] && command_bits[8]) |-> serr_drive
   ) else $error("system error not driven while enabled");

   AST_MASTER_ENABLE: assert property (
      (command_bits[2] && master_want) |-> pci_bus_req
   ) else $error("bus not requested while master enabled");

endmodule

`default_nettype wire

// *** pci_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module pci_host_model (
   input wire logic core_clk,
   output logic req,
   output logic write,
   output logic [31:0] addr,
   output logic [3:0] byte_en,
   output logic [31:0] wdata,
   input wire logic ack,
   input wire logic [31:0] rdata
);
   initial begin
      req = 1'b0;
      write = 1'b0;
      addr = 32'h0000_0000;
      byte_en = 4'h0;
      wdata = 32'h0000_0000;
   end

   // One request, held until the answer or for at most 16 cycles, then released with inverted lines
   task automatic access(input logic w, input logic [31:0] a, input logic [3:0] be,
         input logic [31:0] d, output logic [31:0] rd, output logic ok);
      int n;
      ok = 1'b0;
      rd = 32'h0000_0000;
      @(negedge core_clk);
      req <= 1'b1;
      write <= w;
      addr <= a;
      byte_en <= be;
      wdata <= d;
      for (n = 0; n < 16 && !ok; n++) begin
         @(negedge core_clk);
         if (ack === 1'b1) begin
            ok = 1'b1;
            rd = rdata;
         end
      end
      // Hold through the rising edge that samples the answer
      if (ok) @(negedge core_clk);
      req <= 1'b0;
      write <= ~w;
      addr <= ~a;
      byte_en <= ~be;
      wdata <= ~d;
   endtask
endmodule

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   localparam logic [15:0] VEN = 16'h3C3C;   // Arbitrary value
   localparam logic [15:0] DEV = 16'hC3C3;   // Arbitrary value
   localparam logic [31:0] CLASS_V = 32'h0B40_0003;
   localparam logic [31:0] SUBSYS_V = 32'h1357_9BDF;
   localparam logic [7:0] INTR_V = 8'h01;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic h_req, h_write, c_req, c_write, h_ack, c_ack;
   logic [31:0] h_addr, h_wdata, c_addr, c_wdata, h_rdata, c_rdata;
   logic [3:0] h_be, c_be;
   logic io_hit, mem_hit, spc, m_want, ob_load, ob_ne, mwi_w, fb_w, dpe, ape;
   logic io_cl, mem_cl, spc_cl, pal, ob_acc, ob_dr, breq, mwi_i, fb_i, perr, serr;
   logic [15:0] command_bits;
   logic [31:0] sh [64];
   logic st31 = 1'b0;
   logic [31:0] seed = 32'h08216BDF;
   int n_errors = 0;
   int check_count = 0;

   always #4 core_clk = ~core_clk;

   pci_host_model HOST (.core_clk(core_clk), .req(h_req), .write(h_write), .addr(h_addr),
      .byte_en(h_be), .wdata(h_wdata), .ack(h_ack), .rdata(h_rdata));
   pci_host_model CPU (.core_clk(core_clk), .req(c_req), .write(c_write), .addr(c_addr),
      .byte_en(c_be), .wdata(c_wdata), .ack(c_ack), .rdata(c_rdata));

   pci_config_header_command #(.VENDOR_CODE(VEN), .DEVICE_CODE(DEV), .CLASS_REV(CLASS_V),
      .SUBSYS_CODE(SUBSYS_V), .INTR_PIN(INTR_V)) DUT (
      .core_clk(core_clk), .rstn(rstn), .cfg_req(h_req), .cfg_write(h_write),
      .cfg_index(h_addr[7:2]), .cfg_byte_en(h_be), .cfg_wdata(h_wdata), .cfg_ack(h_ack),
      .cfg_rdata(h_rdata), .lp_req(c_req), .lp_write(c_write), .lp_addr(c_addr),
      .lp_byte_en(c_be), .lp_wdata(c_wdata), .lp_ack(c_ack), .lp_rdata(c_rdata),
      .io_addr_hit(io_hit), .mem_addr_hit(mem_hit), .special_cycle(spc),
      .io_target_claim(io_cl), .mem_target_claim(mem_cl), .special_cycle_claim(spc_cl),
      .palette_snoop(pal), .master_want(m_want), .outbound_load(ob_load),
      .outbound_not_empty(ob_ne), .outbound_accept(ob_acc), .outbound_drain(ob_dr),
      .pci_bus_req(breq), .mwi_want(mwi_w), .mwi_issue(mwi_i), .fb2b_want(fb_w),
      .fb2b_issue(fb_i), .data_parity_err(dpe), .addr_parity_err(ape), .perr_drive(perr),
      .serr_drive(serr), .command_bits(command_bits));

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function logic [15:0] cmd();
      return sh[1][15:0] & pci_cfg_pkg::CMD_RW_MASK[15:0];
   endfunction

   function logic [31:0] exp_dw(input logic [5:0] i);
      case (i)
         6'd0: return {DEV, VEN};
         6'd1: return {st31, 15'h0000, cmd()};
         6'd2: return CLASS_V;
         6'd3: return sh[3] & pci_cfg_pkg::MISC_RW_MASK;
         6'd4: return sh[4] & pci_cfg_pkg::REG_MEM_RW_MASK;
         6'd5: return (sh[5] & pci_cfg_pkg::REG_IO_RW_MASK) | pci_cfg_pkg::REG_IO_FIXED;
         6'd6: return sh[6] & pci_cfg_pkg::LOC_MEM_RW_MASK;
         6'd11: return SUBSYS_V;
         6'd12: return sh[12] & pci_cfg_pkg::ROM_RW_MASK;
         6'd15: return {16'h0000, INTR_V, sh[15][7:0] & pci_cfg_pkg::INTR_RW_MASK[7:0]};
         default: return 32'h0000_0000;
      endcase
   endfunction

   task report_and_stop();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(input logic lp, input logic w, input logic [5:0] idx,
         input logic [3:0] be, input logic [31:0] d);
      logic [31:0] rd;
      logic ok;
      if (lp) CPU.access(w, pci_cfg_pkg::LOCAL_BASE | {24'h0, idx, 2'b00}, be, d, rd, ok);
      else HOST.access(w, {24'h0, idx, 2'b00}, be, d, rd, ok);
      check("ack", {31'h0, ok}, 32'h1);
      if (!ok) report_and_stop();
      if (!w) check("rdata", rd, exp_dw(idx));
      for (int b = 0; b < 4; b++) if (w && be[b]) sh[idx][8*b +: 8] = d[8*b +: 8];
      if (w && idx == 6'd1 && be[3] && d[31]) st31 = 1'b0;
   endtask

   task side(input logic force_err);
      logic [31:0] r;
      logic [15:0] c;
      @(negedge core_clk);
      r = rnd();
      {io_hit, mem_hit, spc, m_want, ob_load, ob_ne, mwi_w, fb_w} = r[7:0];
      dpe = force_err | (r[8] & r[11] & r[12]);
      ape = force_err | (r[9] & r[13] & r[14]);
      #1;
      c = cmd();
      check("command_bits", {16'h0000, command_bits}, {16'h0000, c});
      check("claims", {28'h0, io_cl, mem_cl, spc_cl, pal},
         {28'h0, c[0] & io_hit, c[1] & mem_hit, 2'b00});
      check("master", {27'h0, ob_acc, ob_dr, breq, mwi_i, fb_i},
         {27'h0, ob_load, c[2] & ob_ne, c[2] & (m_want | ob_ne), c[2] & c[4] & mwi_w,
         c[9] & fb_w});
      check("drives", {30'h0, perr, serr},
         {30'h0, c[6] & dpe, c[6] & c[8] & ape});
      @(negedge core_clk);
      if (dpe || ape) st31 = 1'b1;
      dpe = 1'b0;
      ape = 1'b0;
   endtask

   initial begin
      logic [31:0] r, rd;
      logic ok;
      {io_hit, mem_hit, spc, m_want, ob_load, ob_ne, mwi_w, fb_w, dpe, ape} = 10'h000;
      for (int i = 0; i < 64; i++) sh[i] = 32'h0000_0000;
      repeat (10) @(posedge core_clk);
      @(negedge core_clk);
      rstn = 1'b1;
      for (int i = 0; i < 64; i++) bus(1'b0, 1'b0, i[5:0], 4'hF, 32'h0000_0000);
      $display("test reset map done");
      for (int k = 0; k < 2; k++) begin
         bus(1'b0, 1'b1, 6'd1, 4'h3, k ? 32'h0000_0357 : 32'h0000_0000);
         side(1'b1);
         bus(1'b1, 1'b0, 6'd1, 4'hF, 32'h0000_0000);
      end
      bus(1'b0, 1'b1, 6'd1, 4'h8, 32'h8000_0000);
      bus(1'b0, 1'b0, 6'd1, 4'hF, 32'h0000_0000);
      $display("test parity done");
      CPU.access(1'b0, 32'h4200_0100, 4'hF, 32'h0000_0000, rd, ok);
      check("out of window ack", {31'h0, ok}, 32'h0);
      fork
         bus(1'b0, 1'b0, 6'd0, 4'hF, 32'h0000_0000);
         bus(1'b1, 1'b0, 6'd2, 4'hF, 32'h0000_0000);
      join
      $display("test window and collision done");
      for (int i = 0; i < 300; i++) begin
         r = rnd();
         bus(r[0], r[1], r[6] ? 6'd1 : r[13:8], r[19:16], rnd());
         side(1'b0);
      end
      $display("test random traffic done");
      @(negedge core_clk);
      rstn = 1'b0;
      for (int i = 0; i < 64; i++) sh[i] = 32'h0000_0000;
      st31 = 1'b0;
      repeat (2) @(negedge core_clk);
      rstn = 1'b1;
      side(1'b1);
      for (int i = 0; i < 16; i++) bus(1'b1, 1'b0, i[5:0], 4'hF, 32'h0000_0000);
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule

`default_nettype wire
